// [logic/sync_serial_master_xfer.sv]
`default_nettype none
// Functional notes
// - Transmit pin floats until transmit is enabled and the pin is selected.
// - Enabling transmit raises transmit-empty request immediately.
// - Each buffer-to-shifter move raises transmit-empty again.
// - Legacy empty flag set on move, software clears.
// - Full byte received: store, raise receive-full request.
// - Legacy full flag set on receive, software clears.
// - Transmit interrupt disabled: no more transmit requests.
// - Both disabled: transmit pin floats again.
module sync_serial_master_xfer (
  input wire logic MCLK, // 200 MHz clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic [3:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after strobe
  output logic IRQ, // level interrupt
  output logic TXD_O, // serial data out
  output logic TXD_OE, // serial data output enable
  output logic SCK_O, // shift clock out
  output logic SCK_OE, // shift clock output enable
  input wire logic RXD_I // serial data in
);
  logic [7:0] ctrl_r, div_r, txbuf_r, txsh_r, rxsh_r, rxbuf_r;
  logic txbuf_full_r, tx_empty_flag_r, rx_full_flag_r, overrun_r;
  localparam int NIRQ_W = sync_serial_pkg::NIRQ;
  logic [NIRQ_W-1:0] irq_stat_r, irq_en_r;
  logic [7:0] div_cnt_r;
  logic [3:0] bit_cnt_r;
  logic sck_r, busy_r, txd_r, tick;
  logic rxd_s1_r, rxd_s2_r;
  logic tx_on_bit, rx_on_bit, tx_irq_en, rx_irq_en;
  logic load_ev, rx_done_ev, err_ev, tx_on_rise;
  logic tx_on_d_r;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign tx_on_bit = ctrl_r[sync_serial_pkg::CTRL_TX_ON];
  assign rx_on_bit = ctrl_r[sync_serial_pkg::CTRL_RX_ON];
  assign tx_irq_en = ctrl_r[sync_serial_pkg::CTRL_TX_IRQ_EN];
  assign rx_irq_en = ctrl_r[sync_serial_pkg::CTRL_RX_IRQ_EN];

  // Receive data is an outside level, so it is synchronised before use.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
    end else begin
      rxd_s1_r <= RXD_I;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_r <= sync_serial_pkg::CTRL_RESET;
      div_r <= sync_serial_pkg::DIV_RESET;
    end else if (WR) begin
      if (hit(ADDR, sync_serial_pkg::OFS_CTRL)) ctrl_r <= WDATA;
      if (hit(ADDR, sync_serial_pkg::OFS_DIV)) div_r <= WDATA;
    end
  end

  // Half-bit tick: the shift clock toggles once per divisor plus one cycles.
  always_ff @(posedge MCLK) begin
    if (!RST_N || !busy_r) begin
      div_cnt_r <= 8'h00;
    end else if (div_cnt_r == div_r) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  assign tick = busy_r && (div_cnt_r == div_r);

  a_div_restart: assert property (@(posedge MCLK) disable iff (!RST_N)
    tick |=> div_cnt_r == 8'h00)
    else $error("divider did not restart after a half-bit tick");

  // A byte is loaded when idle with data waiting; receive-only runs no transfer, as a load needs transmit on.
  assign load_ev = !busy_r && txbuf_full_r && tx_on_bit;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      busy_r <= 1'b0;
      sck_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      txsh_r <= 8'h00;
      rxsh_r <= 8'h00;
      txd_r <= 1'b1;
    end else if (load_ev) begin
      busy_r <= 1'b1;
      txsh_r <= {1'b0, txbuf_r[7:1]};
      txd_r <= txbuf_r[0];
      bit_cnt_r <= 4'h0;
      sck_r <= 1'b1;
    end else if (tick) begin
      sck_r <= ~sck_r;
      if (sck_r) begin
        // Falling edge presents the next bit; bit 0 already stands from the load.
        if (bit_cnt_r != 4'h0) begin
          txd_r <= txsh_r[0];
          txsh_r <= {1'b0, txsh_r[7:1]};
        end
      end else begin
        // Rising edge: the slave samples now, so transmit data must not move here.
        rxsh_r <= {rxd_s2_r, rxsh_r[7:1]};
        if (bit_cnt_r == 4'(sync_serial_pkg::BITS_PER_BYTE - 1)) begin
          busy_r <= 1'b0;
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
    end
  end
  assign rx_done_ev = tick && !sck_r &&
                      (bit_cnt_r == 4'(sync_serial_pkg::BITS_PER_BYTE - 1)) && rx_on_bit;
  assign err_ev = rx_done_ev && rx_full_flag_r;

  // While busy, data moves only on falling shift clock edges, never while the slave samples it.
  a_txd_steady: assert property (@(posedge MCLK) disable iff (!RST_N)
    (busy_r && !(tick && sck_r)) |=> $stable(txd_r))
    else $error("transmit data moved outside a falling shift clock edge");

  a_bit0_on_load: assert property (@(posedge MCLK) disable iff (!RST_N)
    load_ev |=> txd_r == $past(txbuf_r[0]))
    else $error("first bit not presented on load");

  a_sck_idle_high: assert property (@(posedge MCLK) disable iff (!RST_N)
    !busy_r |-> sck_r)
    else $error("shift clock not high while idle");

  a_byte_end: assert property (@(posedge MCLK) disable iff (!RST_N)
    (tick && !sck_r && bit_cnt_r == 4'(sync_serial_pkg::BITS_PER_BYTE - 1)) |=> !busy_r)
    else $error("shifter ran past the eighth bit");

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      txbuf_r <= 8'h00;
      txbuf_full_r <= 1'b0;
    end else if (WR && hit(ADDR, sync_serial_pkg::OFS_TXDATA) && tx_on_bit) begin
      txbuf_r <= WDATA;
      txbuf_full_r <= 1'b1;
    end else if (load_ev || !tx_on_bit) begin
      txbuf_full_r <= 1'b0;
    end
  end

  a_txdata_refused: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WR && hit(ADDR, sync_serial_pkg::OFS_TXDATA) && !tx_on_bit) |=> !txbuf_full_r)
    else $error("transmit data taken while transmit is off");

  always_ff @(posedge MCLK) begin
    if (!RST_N) tx_on_d_r <= 1'b0;
    else tx_on_d_r <= tx_on_bit;
  end
  assign tx_on_rise = tx_on_bit && !tx_on_d_r;

  // Legacy flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tx_empty_flag_r <= 1'b0;
      rx_full_flag_r <= 1'b0;
      overrun_r <= 1'b0;
      rxbuf_r <= 8'h00;
    end else begin
      if (tx_on_rise || load_ev) tx_empty_flag_r <= 1'b1;
      else if (WR && hit(ADDR, sync_serial_pkg::OFS_FLAG_CLR) &&
               WDATA[sync_serial_pkg::ST_TX_EMPTY]) tx_empty_flag_r <= 1'b0;
      if (rx_done_ev) begin
        rxbuf_r <= {rxd_s2_r, rxsh_r[7:1]};
        rx_full_flag_r <= 1'b1;
      end else if (WR && hit(ADDR, sync_serial_pkg::OFS_FLAG_CLR) &&
                   WDATA[sync_serial_pkg::ST_RX_FULL]) rx_full_flag_r <= 1'b0;
      if (err_ev) overrun_r <= 1'b1;
      else if (WR && hit(ADDR, sync_serial_pkg::OFS_FLAG_CLR) &&
               WDATA[sync_serial_pkg::ST_OVERRUN]) overrun_r <= 1'b0;
    end
  end

  a_tx_flag_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    (tx_empty_flag_r && !(WR && hit(ADDR, sync_serial_pkg::OFS_FLAG_CLR))) |=> tx_empty_flag_r)
    else $error("empty flag dropped without a software clear");

  a_rx_flag_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    (rx_full_flag_r && !(WR && hit(ADDR, sync_serial_pkg::OFS_FLAG_CLR))) |=> rx_full_flag_r)
    else $error("full flag dropped without a software clear");

  a_overrun_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!overrun_r && !err_ev) |=> !overrun_r)
    else $error("overrun flagged without a byte landing on a full buffer");

  logic [NIRQ_W-1:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[sync_serial_pkg::IRQ_TX] = tx_irq_en && (tx_on_rise || load_ev);
    irq_set[sync_serial_pkg::IRQ_RX] = rx_irq_en && rx_done_ev;
    irq_set[sync_serial_pkg::IRQ_ERR] = rx_irq_en && err_ev;
  end

  a_rx_req_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    !rx_irq_en |=> !$rose(irq_stat_r[sync_serial_pkg::IRQ_RX]) &&
                   !$rose(irq_stat_r[sync_serial_pkg::IRQ_ERR]))
    else $error("receive request raised while receive interrupt is off");

  genvar gi;
  generate
    for (gi = 0; gi < NIRQ_W; gi++) begin : g_irq
      always_ff @(posedge MCLK) begin
        if (!RST_N) irq_stat_r[gi] <= 1'b0;
        else if (irq_set[gi]) irq_stat_r[gi] <= 1'b1;
        else if (WR && hit(ADDR, sync_serial_pkg::OFS_IRQ_CLR) && WDATA[gi])
          irq_stat_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    if (!RST_N) irq_en_r <= '0;
    else if (WR && hit(ADDR, sync_serial_pkg::OFS_IRQ_EN)) irq_en_r <= WDATA[NIRQ_W-1:0];
  end
  assign IRQ = |(irq_stat_r & irq_en_r);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        sync_serial_pkg::OFS_CTRL: RDATA <= ctrl_r;
        sync_serial_pkg::OFS_DIV: RDATA <= div_r;
        sync_serial_pkg::OFS_RXDATA: RDATA <= rxbuf_r;
        sync_serial_pkg::OFS_STATUS: RDATA <= {4'h0, busy_r, overrun_r,
                                                rx_full_flag_r, tx_empty_flag_r};
        sync_serial_pkg::OFS_IRQ_STAT: RDATA <= {5'h00, irq_stat_r};
        sync_serial_pkg::OFS_IRQ_EN: RDATA <= {5'h00, irq_en_r};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  a_rdata_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    !RD |=> RDATA == 8'h00)
    else $error("read data shown without a read strobe");

  // The pin is released whenever transmit is off, so no stale level is driven.
  assign TXD_O = txd_r;
  assign TXD_OE = ctrl_r[sync_serial_pkg::CTRL_PIN_SEL] && tx_on_bit;
  assign SCK_O = sck_r;
  assign SCK_OE = tx_on_bit || rx_on_bit;

  // Pin, request, flag and shifter checks; further shifter and flag checks sit beside their logic.
  a_txpin_float: assert property (@(posedge MCLK) disable iff (!RST_N)
    !tx_on_bit |-> !TXD_OE)
    else $error("transmit pin driven while disabled");

  a_tx_en_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($rose(tx_on_bit) && tx_irq_en) |=> irq_stat_r[0])
    else $error("no request on enable");

  a_load_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    (load_ev && tx_irq_en) |=> irq_stat_r[0] && tx_empty_flag_r)
    else $error("no load req");

  a_load_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    load_ev |=> tx_empty_flag_r && busy_r)
    else $error("empty flag not set on load");

  a_rx_store: assert property (@(posedge MCLK) disable iff (!RST_N)
    rx_done_ev |=> rx_full_flag_r && (rxbuf_r == $past(rxd_s2_r) * 8'h80 +
    ($past(rxsh_r) >> 1)))
    else $error("received byte not stored");

  a_no_tx_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!tx_irq_en && !irq_stat_r[0] && !(WR && hit(ADDR, sync_serial_pkg::OFS_CTRL))) |=>
    !irq_stat_r[0])
    else $error("transmit request while disabled");

  a_pins_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(tx_on_bit) |-> !TXD_OE)
    else $error("pin not released");

  a_clock_released: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!tx_on_bit && !rx_on_bit) |-> !SCK_OE)
    else $error("shift clock driven while both directions are off");

  a_eight_bits: assert property (@(posedge MCLK) disable iff (!RST_N)
    busy_r |-> bit_cnt_r < 4'h8)
    else $error("more than eight bits");

  a_overrun_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    (err_ev && rx_irq_en) |=> irq_stat_r[2] && overrun_r)
    else $error("no error req");
endmodule : sync_serial_master_xfer
`default_nettype wire

// [logic/sync_serial_pkg.sv]
`default_nettype none
package sync_serial_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIV = 4'h1;
  localparam logic [3:0] OFS_TXDATA = 4'h2;
  localparam logic [3:0] OFS_RXDATA = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFS_IRQ_EN = 4'h6;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h7;
  localparam logic [3:0] OFS_FLAG_CLR = 4'h8;
  // Control register fields.
  localparam int CTRL_TX_ON = 0;
  localparam int CTRL_RX_ON = 1;
  localparam int CTRL_TX_IRQ_EN = 2;
  localparam int CTRL_RX_IRQ_EN = 3;
  localparam int CTRL_PIN_SEL = 4;
  // Status fields.
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_BUSY = 3;
  // Interrupt request bits.
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  localparam int NIRQ = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam int BITS_PER_BYTE = 8;
endpackage : sync_serial_pkg
`default_nettype wire

// [test/serial_slave_model.sv]
`default_nettype none
module serial_slave_model (
  input wire logic sck, // shift clock from the master
  input wire logic sck_oe, // master drives the clock
  input wire logic txd, // data from the master
  input wire logic [7:0] reply, // byte to hand back
  output logic rxd, // data to the master
  output logic [7:0] got // last byte taken in
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  initial begin
    rxd = 1'b0;
  end
  // Data goes out on the falling edge so it is settled long before the master samples.
  always @(negedge sck) begin
    if (sck_oe) begin
      rxd <= reply[idx];
    end
  end
  always @(posedge sck) begin
    if (sck_oe) begin
      got <= {txd, got[7:1]};
      idx = (idx == 7) ? 0 : idx + 1;
      // Between bytes the line shows the opposite of its last bit, never a stale copy.
      if (idx == 0) begin
        rxd <= ~reply[7];
      end
    end
  end
endmodule : serial_slave_model
`default_nettype wire

// [test/test_sync_serial_master_xfer.sv]
`default_nettype none
module test_sync_serial_master_xfer;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] reply = 8'h3C;
  logic [7:0] RDATA, got;
  logic IRQ, TXD_O, TXD_OE, SCK_O, SCK_OE, RXD_I;
  int mismatches = 0;
  int compares = 0;
  always #2.5 MCLK = ~MCLK;
  sync_serial_master_xfer sync_serial_master_xfer_inst (.MCLK(MCLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .TXD_O(TXD_O), .TXD_OE(TXD_OE), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .RXD_I(RXD_I));
  serial_slave_model serial_slave_model_inst (.sck(SCK_O), .sck_oe(SCK_OE), .txd(TXD_O),
    .reply(reply), .rxd(RXD_I), .got(got));
  task automatic complete_run;
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    check(what, e, RDATA & m);
  endtask : rchk
  // Sends one byte, then polls the busy bit under a bound until the shifter is idle.
  task automatic xfer(input logic [7:0] b);
    int n;
    logic busy;
    wr(sync_serial_pkg::OFS_TXDATA, b);
    busy = 1'b1;
    for (n = 0; n < 200 && busy; n++) begin
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= sync_serial_pkg::OFS_STATUS;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      busy = (RDATA[sync_serial_pkg::ST_BUSY] !== 1'b0);
    end
    check("xfer_done", 8'h00, RDATA & 8'h08);
  endtask : xfer
  task automatic t_idle;
    repeat (2) @(posedge MCLK);
    #1 check("oe_reset", 8'h00, TXD_OE);
    wr(sync_serial_pkg::OFS_CTRL, 8'h10);
    repeat (2) @(posedge MCLK);
    #1 check("oe_sel", 8'h00, TXD_OE);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
  endtask : t_idle
  task automatic t_start;
    wr(sync_serial_pkg::OFS_DIV, 8'h95);
    rchk("div_set", sync_serial_pkg::OFS_DIV, 8'hFF, 8'h95);
    // A short divisor keeps the run brief; the roughly 667-kilobit value is only read back.
    wr(sync_serial_pkg::OFS_DIV, 8'h07);
    repeat (16) @(posedge MCLK);
    wr(sync_serial_pkg::OFS_IRQ_EN, 8'h07);
    wr(sync_serial_pkg::OFS_CTRL, 8'h1C);
    wr(sync_serial_pkg::OFS_CTRL, 8'h1F);
    repeat (2) @(posedge MCLK);
    #1 check("oe_on", 8'h01, TXD_OE);
    check("irq_on", 8'h01, IRQ);
    rchk("txreq_on", sync_serial_pkg::OFS_IRQ_STAT, 8'h01, 8'h01);
    rchk("ctrl_set", sync_serial_pkg::OFS_CTRL, 8'hFF, 8'h1F);
  endtask : t_start
  task automatic t_byte;
    wr(sync_serial_pkg::OFS_IRQ_CLR, 8'h07);
    wr(sync_serial_pkg::OFS_FLAG_CLR, 8'h07);
    xfer(8'hA5);
    check("slave_got", 8'hA5, got);
    rchk("txreq_load", sync_serial_pkg::OFS_IRQ_STAT, 8'h03, 8'h03);
    rchk("status", sync_serial_pkg::OFS_STATUS, 8'h0F, 8'h03);
    rchk("rxdata", sync_serial_pkg::OFS_RXDATA, 8'hFF, 8'h3C);
  endtask : t_byte
  task automatic t_overrun;
    reply <= 8'hC3;
    xfer(8'h5A);
    check("slave_ovr", 8'h5A, got);
    rchk("ovr_flag", sync_serial_pkg::OFS_STATUS, 8'h04, 8'h04);
    rchk("err_req", sync_serial_pkg::OFS_IRQ_STAT, 8'h04, 8'h04);
    rchk("rx_over", sync_serial_pkg::OFS_RXDATA, 8'hFF, 8'hC3);
    wr(sync_serial_pkg::OFS_IRQ_EN, 8'h00);
    repeat (2) @(posedge MCLK);
    #1 check("irq_masked", 8'h00, IRQ);
    wr(sync_serial_pkg::OFS_IRQ_EN, 8'h07);
  endtask : t_overrun
  task automatic t_last;
    wr(sync_serial_pkg::OFS_CTRL, 8'h1B);
    wr(sync_serial_pkg::OFS_IRQ_CLR, 8'h07);
    wr(sync_serial_pkg::OFS_FLAG_CLR, 8'h07);
    xfer(8'h81);
    check("slave_last", 8'h81, got);
    rchk("no_txreq", sync_serial_pkg::OFS_IRQ_STAT, 8'h07, 8'h02);
  endtask : t_last
  task automatic t_stop;
    wr(sync_serial_pkg::OFS_CTRL, 8'h10);
    wr(sync_serial_pkg::OFS_IRQ_CLR, 8'h07);
    repeat (2) @(posedge MCLK);
    #1 check("oe_off", 8'h00, TXD_OE);
    check("sck_off", 8'h00, SCK_OE);
    check("sck_idle", 8'h01, SCK_O);
    check("irq_off", 8'h00, IRQ);
  endtask : t_stop
  initial begin
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    t_idle();
    t_start();
    t_byte();
    t_overrun();
    t_last();
    t_stop();
    complete_run();
  end
  // Three short transfers need well under ten thousand cycles.
  initial begin
    #50000;
    mismatches++;
    complete_run();
  end
endmodule : test_sync_serial_master_xfer
`default_nettype wire
